/* File: dram_refresh_wait_rom.sv */
`timescale 1ns/1ps
module dram_refresh_wait_rom
	import dram_refresh_wait_rom_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_data_sel_i,
	input  wire logic [7:0]  cfg_wdata_i,
	output logic      [7:0]  cfg_rdata_o,
	input  wire logic        slow_clk_32k_i,
	input  wire logic        timer_refresh_i,
	input  wire logic        sleep_i,
	output logic             refresh_pulse_o,
	input  wire logic        mem_req_i,
	input  wire logic        mem_write_i,
	input  wire logic [23:0] mem_addr_i,
	output logic             mem_done_o,
	output logic             dram_row_strobe_o,
	output logic             dram_col_strobe_o,
	output logic             dram_refresh_o,
	output logic             dram_bank_o,
	output logic      [11:0] dram_addr_o,
	input  wire logic        dual_bank_fitted_i,
	input  wire logic        bus_strap_high_i,
	input  wire logic        bus_strap_low_i,
	output logic             local_bus_sel_o,
	output logic             max_isa_sel_o,
	input  wire logic        bus_mem_cycle_i,
	input  wire logic [23:0] bus_addr_i,
	output logic             bios_rom_select_o,
	input  wire logic        wide_mem_ack_i,
	output logic             rom_cycle_wide_o,
	input  wire logic        rom_strobe_i,
	output logic             rom_data_xfer_o
);
	typedef enum logic [2:0] {st_idle, st_row, st_wait, st_col, st_refresh} dram_state_t;

	// ======================================================
	// index/data configuration port
	logic [7:0] index_q;
	logic [7:0] rom2_q, mmw_q, wsc_q, ver_q, rom1_q, mcfg_q, pwr_q;
	logic [1:0] strap_q;
	logic       data_wr;

	assign data_wr = cfg_wr_i & cfg_data_sel_i;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			index_q <= 8'h00;
		end else if (cfg_wr_i && !cfg_data_sel_i) begin
			index_q <= cfg_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rom2_q <= RST_ROM_CONFIG_TWO;
			mmw_q  <= RST_MAPPED_MEM_WAIT_ONE;
			wsc_q  <= RST_WAIT_STATE_CONTROL;
			ver_q  <= RST_VERSION_REFRESH_RATE;
			rom1_q <= RST_ROM_CONFIG_ONE;
			mcfg_q <= RST_MEMORY_CONFIG_ONE;
			pwr_q  <= RST_POWER_CONTROL_ONE;
		end else if (data_wr) begin
			case (index_q)
				IDX_ROM_CONFIG_TWO:       rom2_q <= cfg_wdata_i;
				IDX_MAPPED_MEM_WAIT_ONE:  mmw_q  <= cfg_wdata_i;
				IDX_WAIT_STATE_CONTROL:   wsc_q  <= cfg_wdata_i;
				IDX_VERSION_REFRESH_RATE: ver_q  <= cfg_wdata_i;
				IDX_ROM_CONFIG_ONE:       rom1_q <= cfg_wdata_i;
				IDX_MEMORY_CONFIG_ONE:    mcfg_q <= cfg_wdata_i & MCFG_RW_MASK;
				IDX_POWER_CONTROL_ONE:    pwr_q  <= cfg_wdata_i;
				default: ;
			endcase
		end
	end

	// bit 0 of rom config one reads back inverted
	always_comb begin
		case (index_q)
			IDX_ROM_CONFIG_TWO:       cfg_rdata_o = rom2_q;
			IDX_MAPPED_MEM_WAIT_ONE:  cfg_rdata_o = mmw_q;
			IDX_WAIT_STATE_CONTROL:   cfg_rdata_o = wsc_q;
			IDX_VERSION_REFRESH_RATE: cfg_rdata_o = ver_q;
			IDX_ROM_CONFIG_ONE:       cfg_rdata_o = rom1_q ^ 8'h01;
			IDX_MEMORY_CONFIG_ONE:    cfg_rdata_o = {1'b0, strap_q, mcfg_q[4:0]};
			IDX_POWER_CONTROL_ONE:    cfg_rdata_o = pwr_q;
			default:                  cfg_rdata_o = 8'h00;
		endcase
	end

	// ======================================================
	// pin synchronisers
	logic [1:0] clk32_s, strap_hi_s, strap_lo_s, wide_s, dual_s;
	logic       clk32_d3;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clk32_s    <= 2'h0;
			clk32_d3   <= 1'b0;
			strap_hi_s <= 2'h0;
			strap_lo_s <= 2'h0;
			wide_s     <= 2'h0;
			dual_s     <= 2'h0;
		end else begin
			clk32_s    <= {clk32_s[0], slow_clk_32k_i};
			clk32_d3   <= clk32_s[1];
			strap_hi_s <= {strap_hi_s[0], bus_strap_high_i};
			strap_lo_s <= {strap_lo_s[0], bus_strap_low_i};
			wide_s     <= {wide_s[0], wide_mem_ack_i};
			dual_s     <= {dual_s[0], dual_bank_fitted_i};
		end
	end

	// ======================================================
	// strap capture, once after reset release
	logic [1:0] strap_wait_q;
	logic       strap_done_q;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_wait_q <= 2'h0;
			strap_done_q <= 1'b0;
			strap_q      <= 2'h0;
		end else if (!strap_done_q) begin
			// wait until the synchronisers hold post-reset pin levels
			strap_wait_q <= strap_wait_q + 2'h1;
			if (strap_wait_q == 2'h2) begin
				strap_done_q <= 1'b1;
				strap_q      <= {strap_hi_s[1], strap_lo_s[1]};
			end
		end
	end

	assign local_bus_sel_o = strap_q[1] & ~strap_q[0];
	assign max_isa_sel_o   = strap_q[0];

	// ======================================================
	// refresh pacing
	logic       clk32_rise, clk32_edge, slow_tick, refresh_tick;
	logic [1:0] rate_cnt_q;
	logic       refresh_pend_q;
	dram_state_t state_q;

	assign clk32_rise = clk32_s[1] & ~clk32_d3;
	assign clk32_edge = clk32_s[1] ^ clk32_d3;
	assign slow_tick  = clk32_rise && (rate_cnt_q == ver_q[1:0]);

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rate_cnt_q <= 2'h0;
		end else if (clk32_rise) begin
			rate_cnt_q <= slow_tick ? 2'h0 : rate_cnt_q + 2'h1;
		end
	end

	always_comb begin
		if (pwr_q[PWR_TIMER_SRC_BIT]) begin
			refresh_tick = timer_refresh_i;
		end else if (pwr_q[PWR_FAST_BIT]) begin
			refresh_tick = clk32_edge;
		end else begin
			refresh_tick = slow_tick & ~sleep_i;
		end
	end

	// power manager times its events from this pulse
	assign refresh_pulse_o = refresh_tick;

	// a new tick wins over the clear taken on refresh entry
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			refresh_pend_q <= 1'b0;
		end else if (refresh_tick) begin
			refresh_pend_q <= 1'b1;
		end else if (state_q == st_idle) begin
			refresh_pend_q <= 1'b0;
		end
	end

	// ======================================================
	// dram cycle sequencer
	logic        page_mode, enhanced, page_hit, page_open_q;
	logic [12:0] page_key, open_key_q;
	logic [2:0]  wait_q, first_waits, miss_waits, hit_waits, row_waits;
	logic [2:0]  ref_cnt_q;

	assign page_mode   = (mcfg_q[1:0] == DRAM_MODE_PAGE) | mcfg_q[1];
	assign enhanced    = mcfg_q[MCFG_ENHANCED_BIT] & dual_s[1];
	assign first_waits = {1'b0, wsc_q[WSC_FIRST_HI_BIT], rom1_q[ROM1_FIRST_LO_BIT]};
	assign miss_waits  = {wsc_q[WSC_MISS_HI_BIT], 1'b0, mmw_q[MMW_MISS_LO_BIT]};
	assign hit_waits   = mem_write_i ? PAGE_HIT_WRITE_WAITS : PAGE_HIT_READ_WAITS;
	assign row_waits   = page_open_q ? miss_waits : first_waits;
	// enhanced mode: bank follows the column neighbour bit, so a page spans both
	assign page_key    = enhanced ? {1'b0, mem_addr_i[22:11]} : mem_addr_i[22:10];
	assign dram_bank_o = enhanced ? mem_addr_i[10] : mem_addr_i[22];
	assign page_hit    = page_mode & page_open_q & (page_key == open_key_q);

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q   <= st_idle;
			wait_q    <= 3'h0;
			ref_cnt_q <= 3'h0;
		end else begin
			case (state_q)
				st_idle: begin
					if (refresh_pend_q) begin
						state_q   <= st_refresh;
						ref_cnt_q <= REFRESH_CYCLES - 3'h1;
					end else if (mem_req_i && page_hit) begin
						// no row phase on a hit
						state_q <= (hit_waits == 3'h0) ? st_col : st_wait;
						wait_q  <= hit_waits - 3'h1;
					end else if (mem_req_i) begin
						state_q <= st_row;
					end
				end
				st_row: begin
					state_q <= (row_waits == 3'h0) ? st_col : st_wait;
					wait_q  <= row_waits - 3'h1;
				end
				st_wait: begin
					if (wait_q == 3'h0) begin
						state_q <= st_col;
					end else begin
						wait_q <= wait_q - 3'h1;
					end
				end
				st_col: state_q <= st_idle;
				st_refresh: begin
					if (ref_cnt_q == 3'h0) begin
						state_q <= st_idle;
					end else begin
						ref_cnt_q <= ref_cnt_q - 3'h1;
					end
				end
				default: state_q <= st_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			page_open_q <= 1'b0;
			open_key_q  <= 13'h0000;
		end else if (state_q == st_refresh) begin
			page_open_q <= 1'b0;
		end else if (state_q == st_col) begin
			page_open_q <= page_mode;
			open_key_q  <= page_key;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dram_addr_o <= 12'h000;
		end else if (state_q == st_idle && mem_req_i && !page_hit) begin
			dram_addr_o <= enhanced ? mem_addr_i[22:11] : mem_addr_i[21:10];
		end else if (state_q == st_row || (state_q == st_idle && mem_req_i)) begin
			dram_addr_o <= {3'h0, mem_addr_i[9:1]};
		end
	end

	assign dram_row_strobe_o = (state_q == st_row);
	assign dram_col_strobe_o = (state_q == st_col) || (state_q == st_wait);
	assign dram_refresh_o    = (state_q == st_refresh);
	assign mem_done_o        = (state_q == st_col);

	// ======================================================
	// bios rom decode and rom wait states
	logic       in_boot, in_a, in_cd, in_ef;
	logic [2:0] rom_cnt_q;

	assign in_boot = (bus_addr_i[23:16] == SEG_BOOT_VECTOR);
	assign in_a    = (bus_addr_i[23:16] == SEG_A) & rom2_q[ROM2_A_EN_BIT];
	assign in_cd   = (bus_addr_i[23:17] == SEG_CD) & rom1_q[ROM1_CD_EN_BIT];
	assign in_ef   = (bus_addr_i[23:17] == SEG_EF) & rom1_q[ROM1_EF_EN_BIT]
	               & ~rom1_q[ROM1_EF_OFF_BIT];
	// combinational so the select is valid within the address phase
	assign bios_rom_select_o = bus_mem_cycle_i & (in_boot | in_a | in_cd | in_ef);
	assign rom_cycle_wide_o  = bios_rom_select_o & wide_s[1];

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rom_cnt_q <= 3'h0;
		end else if (!rom_strobe_i) begin
			rom_cnt_q <= 3'h0;
		end else if (rom_cnt_q != wsc_q[2:0]) begin
			rom_cnt_q <= rom_cnt_q + 3'h1;
		end
	end

	assign rom_data_xfer_o = rom_strobe_i & (rom_cnt_q == wsc_q[2:0]);

	// ======================================================
	// checks
	sequence s_idle_hit(logic wr);
		state_q == st_idle && !refresh_pend_q && mem_req_i && page_hit && mem_write_i == wr;
	endsequence

	property p_hit_read;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		s_idle_hit(1'b0) |=> mem_done_o && !dram_row_strobe_o;
	endproperty
	a_hit_read: assert property (p_hit_read) else $error("page-hit read not zero-wait");

	property p_hit_write;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		s_idle_hit(1'b1) |=> !mem_done_o ##1 mem_done_o;
	endproperty
	a_hit_write: assert property (p_hit_write) else $error("page-hit write not one-wait");

	property p_first_three;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		(dram_row_strobe_o && !page_open_q && first_waits == 3'h3)
			|=> (state_q == st_wait)[*3] ##1 mem_done_o;
	endproperty
	a_first_three: assert property (p_first_three) else $error("first-cycle waits wrong");

	property p_refresh_closes;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		dram_refresh_o |=> !page_open_q;
	endproperty
	a_refresh_closes: assert property (p_refresh_closes) else $error("page open after refresh");

	property p_refresh_between;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(dram_refresh_o) |-> $past(state_q) == st_idle;
	endproperty
	a_refresh_between: assert property (p_refresh_between) else $error("refresh cut a cycle");

	property p_refresh_served;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		refresh_tick |-> ##[1:20] dram_refresh_o;
	endproperty
	a_refresh_served: assert property (p_refresh_served) else $error("refresh not run");

	property p_boot_vector;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		bus_mem_cycle_i && bus_addr_i[23:16] == 8'hff |-> bios_rom_select_o;
	endproperty
	a_boot_vector: assert property (p_boot_vector) else $error("boot vector not selected");

	property p_strap_fixed;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		strap_done_q |=> $stable(strap_q) && $stable(max_isa_sel_o);
	endproperty
	a_strap_fixed: assert property (p_strap_fixed) else $error("bus choice changed");

	property p_rom_wait;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		$rose(rom_strobe_i) && wsc_q[2:0] == 3'h2 && $stable(wsc_q)
			|-> !rom_data_xfer_o ##1 !rom_data_xfer_o ##1 (rom_data_xfer_o || !rom_strobe_i);
	endproperty
	a_rom_wait: assert property (p_rom_wait) else $error("rom wait count wrong");

	property p_rom_narrow;
		@(posedge sys_clk_i) disable iff (!arst_n_i)
		bios_rom_select_o && !$past(wide_mem_ack_i, 2) |-> !rom_cycle_wide_o;
	endproperty
	a_rom_narrow: assert property (p_rom_narrow) else $error("rom cycle wide without ack");
endmodule

/* File: dram_refresh_wait_rom_pkg.sv */
// Operation
// - three refresh modes: timer, fast or slow refresh
// - refresh stays enabled except slow refresh in sleep; pulses pace power manager
// - slow refresh rate from version register bits
// - power control xx00: slow, 32 kHz, sleep-off
// - page hit skips the row-address phase
// - page hit: reads zero, writes one wait
// - programmed page-miss and first-cycle wait states
// - first-cycle wait count resets to three
// - wait fields split over three registers
// - memory config low bits 10: page mode
// - memory config bits 7-5 read only
// - enhanced mode spreads one page across banks
// - straps latched at reset into bits 6-5
// - bus choice only from straps, never writes
// - bios select with 24 address lines
// - bios select for enabled low-memory ranges
// - boot-vector range always selects bios rom
// - rom cycles 8-bit unless wide acknowledge
// - programmed rom waits before data transfer
// - four slow rates, slowest at reset
// - power control 10 fast rate, x1 timer
package dram_refresh_wait_rom_pkg;
	// ======================================================
	// register indexes
	localparam logic [7:0] IDX_ROM_CONFIG_TWO        = 8'h51;
	localparam logic [7:0] IDX_MAPPED_MEM_WAIT_ONE   = 8'h62;
	localparam logic [7:0] IDX_WAIT_STATE_CONTROL    = 8'h63;
	localparam logic [7:0] IDX_VERSION_REFRESH_RATE  = 8'h64;
	localparam logic [7:0] IDX_ROM_CONFIG_ONE        = 8'h65;
	localparam logic [7:0] IDX_MEMORY_CONFIG_ONE     = 8'h66;
	localparam logic [7:0] IDX_POWER_CONTROL_ONE     = 8'ha7;
	// ======================================================
	// reset values
	localparam logic [7:0] RST_ROM_CONFIG_TWO        = 8'h01;
	localparam logic [7:0] RST_MAPPED_MEM_WAIT_ONE   = 8'h00;
	localparam logic [7:0] RST_WAIT_STATE_CONTROL    = 8'h40;
	localparam logic [7:0] RST_VERSION_REFRESH_RATE  = 8'h03;
	localparam logic [7:0] RST_ROM_CONFIG_ONE        = 8'h22;
	localparam logic [7:0] RST_MEMORY_CONFIG_ONE     = 8'h02;
	localparam logic [7:0] RST_POWER_CONTROL_ONE     = 8'h00;
	// ======================================================
	// field positions
	localparam int WSC_FIRST_HI_BIT   = 6;
	localparam int WSC_MISS_HI_BIT    = 5;
	localparam int MMW_MISS_LO_BIT    = 4;
	localparam int ROM1_FIRST_LO_BIT  = 5;
	localparam int ROM1_CD_EN_BIT     = 2;
	localparam int ROM1_EF_EN_BIT     = 1;
	localparam int ROM1_EF_OFF_BIT    = 0;
	localparam int ROM2_A_EN_BIT      = 0;
	localparam int MCFG_ENHANCED_BIT  = 0;
	localparam int MCFG_STRAP_LO_BIT  = 5;
	localparam int MCFG_STRAP_HI_BIT  = 6;
	localparam int PWR_TIMER_SRC_BIT  = 0;
	localparam int PWR_FAST_BIT       = 1;
	localparam logic [1:0] DRAM_MODE_PAGE    = 2'h2;
	localparam logic [7:0] MCFG_RW_MASK      = 8'h1f;
	// ======================================================
	// timing counts and decode ranges
	localparam logic [2:0] PAGE_HIT_READ_WAITS  = 3'h0;
	localparam logic [2:0] PAGE_HIT_WRITE_WAITS = 3'h1;
	localparam logic [2:0] REFRESH_CYCLES       = 3'h2;
	localparam logic [7:0] SEG_BOOT_VECTOR = 8'hff;
	localparam logic [7:0] SEG_A           = 8'h0a;
	localparam logic [6:0] SEG_CD          = 7'h06;
	localparam logic [6:0] SEG_EF          = 7'h07;
endpackage

/* File: dram_refresh_wait_rom_tb.sv */
`timescale 1ns/1ps
module dram_refresh_wait_rom_tb;
	import dram_refresh_wait_rom_pkg::*;
	// ==========================================
	// signals
	logic        sys_clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        cfg_wr = 1'b0;
	logic        cfg_sel = 1'b0;
	logic [7:0]  cfg_wdata = 8'h00;
	logic        slow_clk = 1'b0;
	logic        timer_ref = 1'b0;
	logic        sleep = 1'b0;
	logic        mem_req = 1'b0;
	logic        mem_write = 1'b0;
	logic [23:0] mem_addr = 24'h000000;
	logic        dual_bank = 1'b0;
	logic        strap_hi = 1'b1;
	logic        strap_lo = 1'b0;
	logic [23:0] bus_addr = 24'hff0000;
	logic        wide_part = 1'b0;
	logic        rom_strobe = 1'b0;
	logic [7:0]  rdata;
	logic        ref_pulse, done, row, dref, bank, local_sel, max_sel, rom_sel, wide, xfer;
	logic        wide_ack;
	logic        col;
	logic [11:0] dram_addr;
	logic        bus_cycle = 1'b1;
	int          ref_seen;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          tick_count = 0;

	dram_refresh_wait_rom dut (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr),
		.cfg_data_sel_i(cfg_sel), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(rdata),
		.slow_clk_32k_i(slow_clk), .timer_refresh_i(timer_ref), .sleep_i(sleep),
		.refresh_pulse_o(ref_pulse), .mem_req_i(mem_req), .mem_write_i(mem_write),
		.mem_addr_i(mem_addr), .mem_done_o(done), .dram_row_strobe_o(row),
		.dram_col_strobe_o(col), .dram_refresh_o(dref), .dram_bank_o(bank),
		.dram_addr_o(dram_addr), .dual_bank_fitted_i(dual_bank),
		.bus_strap_high_i(strap_hi), .bus_strap_low_i(strap_lo),
		.local_bus_sel_o(local_sel), .max_isa_sel_o(max_sel),
		.bus_mem_cycle_i(bus_cycle), .bus_addr_i(bus_addr), .bios_rom_select_o(rom_sel),
		.wide_mem_ack_i(wide_ack), .rom_cycle_wide_o(wide), .rom_strobe_i(rom_strobe),
		.rom_data_xfer_o(xfer)
	);
	dram_rom_partner far_side (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bios_rom_select_i(rom_sel),
		.wide_part_i(wide_part), .dram_refresh_i(dref), .wide_mem_ack_o(wide_ack),
		.refresh_seen_o(ref_seen)
	);

	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		if (ref_pulse === 1'b1)
			tick_count <= tick_count + 1;
	end

	// ==========================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic done_test(input string name);
		$display("test %s finished, mismatches so far %0d", name, num_errors);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cfg_put(input logic sel, input logic [7:0] d);
		@(posedge sys_clk_i);
		cfg_wr <= 1'b1;
		cfg_sel <= sel;
		cfg_wdata <= d;
		@(posedge sys_clk_i);
		cfg_wr <= 1'b0;
		cfg_sel <= 1'b1;
	endtask
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		cfg_put(1'b0, idx);
		cfg_put(1'b1, d);
	endtask
	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
		cfg_put(1'b0, idx);
		@(negedge sys_clk_i);
		d = rdata;
	endtask
	task automatic do_reset(input logic hi, input logic lo);
		@(posedge sys_clk_i);
		arst_n_i <= 1'b0;
		strap_hi <= hi;
		strap_lo <= lo;
		repeat (20) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask
	task automatic probe(input logic on_bus, input logic [23:0] a, input logic e);
		@(posedge sys_clk_i);
		if (on_bus)
			bus_addr <= a;
		else
			mem_addr <= a;
		@(negedge sys_clk_i);
		check(on_bus ? "rom select" : "dram bank", on_bus ? rom_sel : bank, e);
	endtask
	task automatic mem_acc(input logic [23:0] a, input logic wr, input int lat, input int rows);
		int k;
		int r;
		int c;
		k = 0;
		r = 0;
		c = 0;
		@(posedge sys_clk_i);
		mem_req <= 1'b1;
		mem_write <= wr;
		mem_addr <= a;
		@(negedge sys_clk_i);
		while (done !== 1'b1 && k < 40) begin
			@(negedge sys_clk_i);
			k++;
			r += int'(row === 1'b1);
			c += int'(col === 1'b1);
			if (row === 1'b1)
				check("row address", dram_addr, {20'h0, a[21:10]});
		end
		check("column address", dram_addr, {23'h0, a[9:1]});
		@(posedge sys_clk_i);
		mem_req <= 1'b0;
		check("access latency", k, lat);
		check("row phases", r, rows);
		check("column phases", c, lat - rows);
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		logic [7:0] idx [8] = '{IDX_ROM_CONFIG_TWO, IDX_MAPPED_MEM_WAIT_ONE,
			IDX_WAIT_STATE_CONTROL, IDX_VERSION_REFRESH_RATE, IDX_ROM_CONFIG_ONE,
			IDX_MEMORY_CONFIG_ONE, IDX_POWER_CONTROL_ONE, 8'h70};
		logic [7:0] rv [8] = '{RST_ROM_CONFIG_TWO, RST_MAPPED_MEM_WAIT_ONE,
			RST_WAIT_STATE_CONTROL, RST_VERSION_REFRESH_RATE, RST_ROM_CONFIG_ONE,
			RST_MEMORY_CONFIG_ONE | 8'h40, RST_POWER_CONTROL_ONE, 8'h00};
		logic [7:0] d;
		// rom config one bit 0 reads inverted, so it is left out
		for (int i = 0; i < 8; i++) begin
			reg_rd(idx[i], d);
			check("reset value", d & ((i == 4) ? 8'hfe : 8'hff), rv[i]);
		end
		reg_wr(IDX_MEMORY_CONFIG_ONE, 8'hff);
		reg_rd(IDX_MEMORY_CONFIG_ONE, d);
		check("memory config", d, 8'h40 | MCFG_RW_MASK);
		check("local bus", local_sel, 1'b1);
		reg_wr(IDX_MEMORY_CONFIG_ONE, 8'h02);
		done_test("registers");
	endtask
	task automatic t_straps();
		for (int i = 0; i < 4; i++) begin
			do_reset(i[1], i[0]);
			check("local bus", local_sel, i[1] & ~i[0]);
			check("max bus", max_sel, i[0]);
		end
		do_reset(1'b1, 1'b0);
		done_test("straps");
	endtask
	task automatic t_rom_decode();
		logic [23:0] a [10] = '{24'hff0000, 24'hffffff, 24'h0a0000, 24'h0b0000, 24'h0c0000,
			24'h0e0000, 24'h0affff, 24'h0d0000, 24'h0f0000, 24'hff8000};
		logic [9:0]  e = 10'h2a7;
		for (int i = 0; i < 6; i++)
			probe(1'b1, a[i], e[i]);
		reg_wr(IDX_ROM_CONFIG_TWO, 8'h00);
		reg_wr(IDX_ROM_CONFIG_ONE, 8'h24);
		for (int i = 6; i < 10; i++)
			probe(1'b1, a[i], e[i]);
		reg_wr(IDX_ROM_CONFIG_ONE, 8'h22);
		reg_wr(IDX_ROM_CONFIG_TWO, 8'h01);
		done_test("rom decode");
	endtask
	task automatic t_wide();
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk_i);
			wide_part <= i[0];
			probe(1'b1, 24'hff0000, 1'b1);
			repeat (4) @(negedge sys_clk_i);
			check("wide cycle", wide, i[0]);
		end
		probe(1'b1, 24'h0b0000, 1'b0);
		repeat (4) @(negedge sys_clk_i);
		check("wide cycle", wide, 1'b0);
		@(posedge sys_clk_i);
		bus_cycle <= 1'b0;
		probe(1'b1, 24'hff0000, 1'b0);
		@(posedge sys_clk_i);
		bus_cycle <= 1'b1;
		probe(1'b1, 24'hff0000, 1'b1);
		done_test("rom width");
	endtask
	task automatic t_rom_wait();
		for (int n = 0; n < 8; n++) begin
			reg_wr(IDX_WAIT_STATE_CONTROL, 8'h40 | n[7:0]);
			@(posedge sys_clk_i);
			rom_strobe <= 1'b1;
			for (int k = 0; k <= n; k++) begin
				@(negedge sys_clk_i);
				check("rom transfer", xfer, k >= n);
			end
			@(posedge sys_clk_i);
			rom_strobe <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
		end
		reg_wr(IDX_WAIT_STATE_CONTROL, RST_WAIT_STATE_CONTROL);
		done_test("rom waits");
	endtask
	task automatic t_dram();
		logic [7:0] d;
		int s;
		int h;
		mem_acc(24'h000100, 1'b0, 5, 1);
		mem_acc(24'h000102, 1'b0, 1, 0);
		mem_acc(24'h000104, 1'b1, 2, 0);
		mem_acc(24'h100100, 1'b0, 2, 1);
		reg_wr(IDX_WAIT_STATE_CONTROL, 8'h60);
		reg_wr(IDX_MAPPED_MEM_WAIT_ONE, 8'h10);
		reg_rd(IDX_WAIT_STATE_CONTROL, d);
		check("wait control", d, 8'h60);
		mem_acc(24'h000100, 1'b1, 7, 1);
		s = ref_seen;
		h = 0;
		reg_wr(IDX_POWER_CONTROL_ONE, 8'h01);
		@(posedge sys_clk_i);
		timer_ref <= 1'b1;
		@(negedge sys_clk_i);
		check("refresh tick", ref_pulse, 1'b1);
		@(posedge sys_clk_i);
		timer_ref <= 1'b0;
		repeat (12) begin
			@(negedge sys_clk_i);
			h += int'(dref === 1'b1);
		end
		check("refresh count", ref_seen - s, 1);
		check("refresh length", h, 2);
		mem_acc(24'h000100, 1'b0, 5, 1);
		reg_wr(IDX_MEMORY_CONFIG_ONE, 8'h00);
		mem_acc(24'h000102, 1'b0, 7, 1);
		reg_wr(IDX_MEMORY_CONFIG_ONE, 8'h02);
		reg_wr(IDX_POWER_CONTROL_ONE, 8'h00);
		reg_wr(IDX_WAIT_STATE_CONTROL, RST_WAIT_STATE_CONTROL);
		reg_wr(IDX_MAPPED_MEM_WAIT_ONE, 8'h00);
		done_test("dram");
	endtask
	task automatic t_enhanced();
		@(posedge sys_clk_i);
		dual_bank <= 1'b1;
		reg_wr(IDX_MEMORY_CONFIG_ONE, 8'h03);
		probe(1'b0, 24'h000400, 1'b1);
		probe(1'b0, 24'h400000, 1'b0);
		@(posedge sys_clk_i);
		dual_bank <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		probe(1'b0, 24'h000400, 1'b0);
		probe(1'b0, 24'h400000, 1'b1);
		reg_wr(IDX_MEMORY_CONFIG_ONE, 8'h02);
		done_test("enhanced page");
	endtask
	task automatic t_rates();
		logic [7:0] pw [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01};
		int         ex [7] = '{12, 6, 4, 3, 24, 0, 0};
		int t;
		int s;
		// twelve slow edges divide evenly by every rate, so phase is irrelevant
		for (int i = 0; i < 7; i++) begin
			reg_wr(IDX_POWER_CONTROL_ONE, pw[i]);
			reg_wr(IDX_VERSION_REFRESH_RATE, {6'h00, i[1:0]});
			@(posedge sys_clk_i);
			sleep <= (i == 5);
			repeat (8) @(posedge sys_clk_i);
			t = tick_count;
			s = ref_seen;
			repeat (12) begin
				repeat (20) @(posedge sys_clk_i);
				slow_clk <= 1'b1;
				repeat (20) @(posedge sys_clk_i);
				slow_clk <= 1'b0;
			end
			repeat (20) @(posedge sys_clk_i);
			check("refresh ticks", tick_count - t, ex[i]);
			check("dram refreshes", ref_seen - s, ex[i]);
		end
		reg_wr(IDX_VERSION_REFRESH_RATE, RST_VERSION_REFRESH_RATE);
		reg_wr(IDX_POWER_CONTROL_ONE, 8'h00);
		done_test("refresh rates");
	endtask

	// ==========================================
	// sequence and watchdog
	initial begin
		do_reset(1'b1, 1'b0);
		t_regs();
		t_straps();
		t_rom_decode();
		t_wide();
		t_rom_wait();
		t_dram();
		t_enhanced();
		t_rates();
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		num_errors++;
		complete_run();
	end
endmodule

/* File: dram_rom_partner.sv */
`timescale 1ns/1ps
module dram_rom_partner (
	input  wire logic sys_clk_i,
	input  wire logic arst_n_i,
	input  wire logic bios_rom_select_i,
	input  wire logic wide_part_i,
	input  wire logic dram_refresh_i,
	output logic      wide_mem_ack_o,
	output int        refresh_seen_o
);
	// ==========================================
	// rom width answer and refresh observer
	logic ref_q;
	// a 16-bit part only answers while it is selected
	assign wide_mem_ack_o = bios_rom_select_i & wide_part_i;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_q <= 1'b0;
			refresh_seen_o <= 0;
		end else begin
			ref_q <= dram_refresh_i;
			if (dram_refresh_i && !ref_q)
				refresh_seen_o <= refresh_seen_o + 1;
		end
	end
endmodule
